// *** hdl/irq_flag_enable_bank.sv ***
// interrupt flag and enable bank with apb register access
// Function
// - every implemented flag and enable bit is read/write and resets to zero
// - flag one means its source raised a request, zero means none
// - enable one permits the matching request, zero leaves it disabled
// - third flag bits 3..0: can a event, can a rx ready, spi b event, spi b error
// - fourth flag bits 15-14 and 12-9 always read zero
// - fourth flag: bit 13 dma 5 done, bit 8 can b event, bit 7 rx ready
// - fourth flag: bits 6,5 ext irq 4,3; bits 4,3,0 timers 9,8,7
// - fourth flag: bit 2 i2c b master, bit 1 i2c b slave
// - fifth flag: 15-8 zero, 7,6 can tx requests, 5,4 dma 7,6 done
// - fifth flag: bit 2 uart b error, bit 1 uart a error, bits 3,0 zero
// - first enable: bit 15 zero, 14..11 dma1, adc a, uart a tx, rx
// - first enable: bits 10..7 spi a event, error, timer 3, timer 2
// - first enable: bits 6..0 oc2, ic2, dma0, timer1, oc1, ic1, ext irq0
// - second enable: 15..11 uart b tx, rx, ext irq2, timer 5, timer 4
// - second enable: 10..4 oc4, oc3, dma2, ic8, ic7, adc b, ext irq1
// - second enable: bit 3 change notify, bit 2 reads zero
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module irq_flag_enable_bank (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // source set pulses for the three flag registers
    input wire logic [15:0] src_set_2,
    input wire logic [15:0] src_set_3,
    input wire logic [15:0] src_set_4,
    // enables of the three flag registers, held elsewhere
    input wire logic [15:0] ext_enable_2,
    input wire logic [15:0] ext_enable_3,
    input wire logic [15:0] ext_enable_4,
    // flags matching the two enable registers, held elsewhere
    input wire logic [15:0] ext_flag_0,
    input wire logic [15:0] ext_flag_1,
    // per-source flag and enable levels
    output logic [15:0] flag_2,
    output logic [15:0] flag_3,
    output logic [15:0] flag_4,
    output logic [15:0] enable_0,
    output logic [15:0] enable_1,
    // pending requests toward the priority logic
    output logic [15:0] pending_2,
    output logic [15:0] pending_3,
    output logic [15:0] pending_4,
    output logic [15:0] pending_0,
    output logic [15:0] pending_1,
    // bank interrupt
    output logic irq
);
    logic [15:0] set_vec [irq_bank_pkg::NUM_REGS];
    logic [15:0] reg_q [irq_bank_pkg::NUM_REGS];
    logic [irq_bank_pkg::NUM_REGS-1:0] reg_wr;
    logic setup_ph;
    logic access_done;
    logic wr_go;
    logic addr_hit;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [1:0] evt_sts_r;
    logic [1:0] evt_en_r;
    logic [1:0] evt_in;
    logic [1:0] evt_sts_nxt;
    logic irq_r;
    logic [15:0] flag_2_r;
    logic [15:0] flag_3_r;
    logic [15:0] flag_4_r;
    logic [15:0] enable_0_r;
    logic [15:0] enable_1_r;
    logic [15:0] pending_2_r;
    logic [15:0] pending_3_r;
    logic [15:0] pending_4_r;
    logic [15:0] pending_0_r;
    logic [15:0] pending_1_r;

    // true for every offset the bank answers
    function automatic logic mapped(input logic [7:0] a);
        case (a)
            irq_bank_pkg::OFS_FLAG_2,
            irq_bank_pkg::OFS_FLAG_3,
            irq_bank_pkg::OFS_FLAG_4,
            irq_bank_pkg::OFS_ENABLE_0,
            irq_bank_pkg::OFS_ENABLE_1,
            irq_bank_pkg::OFS_EVT_STATUS,
            irq_bank_pkg::OFS_EVT_CLEAR,
            irq_bank_pkg::OFS_EVT_ENABLE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // apb phases: one access cycle, no extra wait states
    assign setup_ph = psel & ~penable;
    assign access_done = psel & penable & pready_r;
    assign addr_hit = mapped(paddr);
    assign wr_go = access_done & pwrite & addr_hit;

    // only the sources inside this bank set flags; enables have no hardware set
    assign set_vec[0] = src_set_2;
    assign set_vec[1] = src_set_3;
    assign set_vec[2] = src_set_4;
    assign set_vec[3] = irq_bank_pkg::RST_REG;
    assign set_vec[4] = irq_bank_pkg::RST_REG;

    // the five bank registers share one structure, differing only in mask
    genvar i;
    generate
        for (i = 0; i < irq_bank_pkg::NUM_REGS; i++) begin : g_reg
            assign reg_wr[i] = wr_go & (paddr == irq_bank_pkg::reg_offset(i));
            sticky_reg16 #(
                .IMPL_MASK(irq_bank_pkg::reg_mask(i))
            ) u_reg (
                .mclk(mclk),
                .rst(rst),
                .hw_set(set_vec[i]),
                .sw_wr(reg_wr[i]),
                .sw_data(pwdata[15:0]),
                .value(reg_q[i])
            );
        end
    endgenerate

    // read data mux; unimplemented and upper bits read zero
    function automatic logic [31:0] read_word(input logic [7:0] a);
        read_word = 32'h0000_0000;
        case (a)
            irq_bank_pkg::OFS_FLAG_2: read_word[15:0] = reg_q[0];
            irq_bank_pkg::OFS_FLAG_3: read_word[15:0] = reg_q[1];
            irq_bank_pkg::OFS_FLAG_4: read_word[15:0] = reg_q[2];
            irq_bank_pkg::OFS_ENABLE_0: read_word[15:0] = reg_q[3];
            irq_bank_pkg::OFS_ENABLE_1: read_word[15:0] = reg_q[4];
            irq_bank_pkg::OFS_EVT_STATUS: read_word[1:0] = evt_sts_r;
            irq_bank_pkg::OFS_EVT_ENABLE: read_word[1:0] = evt_en_r;
            default: read_word = 32'h0000_0000;
        endcase
    endfunction

    // answer in the first access cycle; data captured at the setup edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup_ph;
            pslverr_r <= setup_ph & ~addr_hit;
            prdata_r <= (setup_ph & ~pwrite) ? read_word(paddr) : 32'h0000_0000;
        end
    end

    // bank events: a captured request or an unmapped access
    assign evt_in[irq_bank_pkg::EVT_REQUEST] = |((src_set_2 & irq_bank_pkg::MASK_FLAG_2)
        | (src_set_3 & irq_bank_pkg::MASK_FLAG_3) | (src_set_4 & irq_bank_pkg::MASK_FLAG_4));
    assign evt_in[irq_bank_pkg::EVT_BUS_ERR] = access_done & ~addr_hit;

    // sticky status; a new event outlives a clear in the same cycle
    always_comb begin
        evt_sts_nxt = evt_sts_r;
        if (wr_go && paddr == irq_bank_pkg::OFS_EVT_CLEAR) begin
            evt_sts_nxt = evt_sts_r & ~pwdata[1:0];
        end
        evt_sts_nxt = evt_sts_nxt | evt_in;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            evt_sts_r <= irq_bank_pkg::RST_EVT;
        end else begin
            evt_sts_r <= evt_sts_nxt;
        end
    end

    // event enable register
    always_ff @(posedge mclk) begin
        if (rst) begin
            evt_en_r <= irq_bank_pkg::RST_EVT;
        end else if (wr_go && paddr == irq_bank_pkg::OFS_EVT_ENABLE) begin
            evt_en_r <= pwdata[1:0];
        end
    end

    // level interrupt, one cycle behind the status it reflects
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(evt_sts_r & evt_en_r);
        end
    end

    // registered copies so every output leaves a flop
    always_ff @(posedge mclk) begin
        if (rst) begin
            flag_2_r <= irq_bank_pkg::RST_REG;
            flag_3_r <= irq_bank_pkg::RST_REG;
            flag_4_r <= irq_bank_pkg::RST_REG;
            enable_0_r <= irq_bank_pkg::RST_REG;
            enable_1_r <= irq_bank_pkg::RST_REG;
        end else begin
            flag_2_r <= reg_q[0];
            flag_3_r <= reg_q[1];
            flag_4_r <= reg_q[2];
            enable_0_r <= reg_q[3];
            enable_1_r <= reg_q[4];
        end
    end

    // pending only while flag and enable are both one
    always_ff @(posedge mclk) begin
        if (rst) begin
            pending_2_r <= irq_bank_pkg::RST_REG;
            pending_3_r <= irq_bank_pkg::RST_REG;
            pending_4_r <= irq_bank_pkg::RST_REG;
            pending_0_r <= irq_bank_pkg::RST_REG;
            pending_1_r <= irq_bank_pkg::RST_REG;
        end else begin
            pending_2_r <= reg_q[0] & ext_enable_2;
            pending_3_r <= reg_q[1] & ext_enable_3;
            pending_4_r <= reg_q[2] & ext_enable_4;
            pending_0_r <= ext_flag_0 & reg_q[3] & irq_bank_pkg::MASK_ENABLE_0;
            pending_1_r <= ext_flag_1 & reg_q[4] & irq_bank_pkg::MASK_ENABLE_1;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign flag_2 = flag_2_r;
    assign flag_3 = flag_3_r;
    assign flag_4 = flag_4_r;
    assign enable_0 = enable_0_r;
    assign enable_1 = enable_1_r;
    assign pending_2 = pending_2_r;
    assign pending_3 = pending_3_r;
    assign pending_4 = pending_4_r;
    assign pending_0 = pending_0_r;
    assign pending_1 = pending_1_r;

    // checks on the bank behaviour
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_RESET_CLEARS: assert property (disable iff (1'b0) rst
        |=> (reg_q[0] == 16'h0000) && (reg_q[1] == 16'h0000)
        && (reg_q[2] == 16'h0000) && (reg_q[3] == 16'h0000) && (reg_q[4] == 16'h0000))
        else $error("bank register not zero after reset");
    AST_ENABLE_WRITE: assert property (wr_go && paddr == irq_bank_pkg::OFS_ENABLE_0
        |=> reg_q[3] == ($past(pwdata[15:0]) & irq_bank_pkg::MASK_ENABLE_0))
        else $error("enable register write not stored");
    AST_CAN_B_SET: assert property (src_set_3[irq_bank_pkg::CAN_B_EVENT_FLAG]
        |=> reg_q[1][irq_bank_pkg::CAN_B_EVENT_FLAG] ##1 flag_3[irq_bank_pkg::CAN_B_EVENT_FLAG])
        else $error("source pulse did not reach its flag");
    AST_SET_WINS: assert property (src_set_3[irq_bank_pkg::CAN_B_EVENT_FLAG] && reg_wr[1]
        && !pwdata[irq_bank_pkg::CAN_B_EVENT_FLAG] |=> reg_q[1][irq_bank_pkg::CAN_B_EVENT_FLAG])
        else $error("software clear beat a hardware set");
    AST_FLAG_HOLDS: assert property (reg_q[2][irq_bank_pkg::UART_A_ERROR_FLAG] && !reg_wr[2]
        |=> reg_q[2][irq_bank_pkg::UART_A_ERROR_FLAG])
        else $error("flag dropped without a software write");
    AST_UNIMPL_ZERO: assert property (psel && !penable && !pwrite
        && paddr == irq_bank_pkg::OFS_FLAG_3 |=> (prdata[15:14] == 2'h0) && (prdata[12:9] == 4'h0))
        else $error("unimplemented flag bits read nonzero");
    AST_FIFTH_ZERO: assert property (psel && !penable && !pwrite
        && paddr == irq_bank_pkg::OFS_FLAG_4 |=> (prdata[15:8] == 8'h00) && !prdata[3] && !prdata[0])
        else $error("fifth flag reserved bits read nonzero");
    AST_ENABLE_RSVD: assert property (psel && !penable && !pwrite
        && paddr == irq_bank_pkg::OFS_ENABLE_1 |=> !prdata[2] && (prdata[31:16] == 16'h0000))
        else $error("second enable bit 2 read nonzero");
    AST_PENDING: assert property (##1 pending_3 == ($past(reg_q[1]) & $past(ext_enable_3)))
        else $error("pending request not flag and enable");
    AST_PENDING_EN: assert property (ext_flag_1[irq_bank_pkg::CHANGE_NOTIFY_ENABLE]
        && !reg_q[4][irq_bank_pkg::CHANGE_NOTIFY_ENABLE] |=> !pending_1[irq_bank_pkg::CHANGE_NOTIFY_ENABLE])
        else $error("disabled request shown as pending");
    AST_READY_ONE: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not exactly one access cycle");
    AST_IRQ: assert property (evt_sts_r[irq_bank_pkg::EVT_BUS_ERR] && evt_en_r[irq_bank_pkg::EVT_BUS_ERR]
        |=> irq)
        else $error("enabled event did not raise the interrupt");

    // reset and bus answer
    AST_RESET_OUTS: assert property (disable iff (1'b0) rst
        |=> !irq && !pready && (flag_3 == 16'h0000) && (enable_1 == 16'h0000))
        else $error("outputs not cleared by reset");
    AST_ERR_READY: assert property (pslverr
        |-> pready)
        else $error("error answer without ready");
    AST_RDATA_IDLE: assert property (!pready
        |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    AST_EVT_CLEAR: assert property (wr_go && paddr == irq_bank_pkg::OFS_EVT_CLEAR
        && pwdata[irq_bank_pkg::EVT_BUS_ERR] |=> !evt_sts_r[irq_bank_pkg::EVT_BUS_ERR])
        else $error("event clear lost");
    AST_IRQ_LOW: assert property (!(|(evt_sts_r & evt_en_r))
        |=> !irq)
        else $error("interrupt without enabled event");

    // each source pulse reaches its own flag bit
    AST_SPI_B_SET: assert property (src_set_2[irq_bank_pkg::SPI_B_EVENT_FLAG]
        |=> reg_q[0][irq_bank_pkg::SPI_B_EVENT_FLAG])
        else $error("spi b flag not set");
    AST_EXT4_SET: assert property (src_set_3[irq_bank_pkg::EXT_IRQ4_FLAG]
        |=> reg_q[1][irq_bank_pkg::EXT_IRQ4_FLAG])
        else $error("ext irq4 flag not set");
    AST_I2C_B_SET: assert property (src_set_3[irq_bank_pkg::I2C_B_MASTER_FLAG]
        |=> reg_q[1][irq_bank_pkg::I2C_B_MASTER_FLAG])
        else $error("i2c b flag not set");
    AST_DMA7_SET: assert property (src_set_4[irq_bank_pkg::DMA_CH7_DONE_FLAG]
        |=> reg_q[2][irq_bank_pkg::DMA_CH7_DONE_FLAG])
        else $error("dma 7 flag not set");
    AST_UART_B_SET: assert property (src_set_4[irq_bank_pkg::UART_B_ERROR_FLAG]
        |=> reg_q[2][irq_bank_pkg::UART_B_ERROR_FLAG])
        else $error("uart b flag not set");

    // outputs trail their registers by one cycle
    AST_FLAG_COPY: assert property (1'b1
        |=> flag_4 == $past(reg_q[2]))
        else $error("flag output stale");
    AST_ENABLE_COPY: assert property (1'b1
        |=> enable_0 == $past(reg_q[3]))
        else $error("enable output stale");
    AST_ENABLE1_WRITE: assert property (wr_go && paddr == irq_bank_pkg::OFS_ENABLE_1
        |=> reg_q[4] == ($past(pwdata[15:0]) & irq_bank_pkg::MASK_ENABLE_1))
        else $error("second enable write not stored");
    AST_PENDING_0: assert property (1'b1
        |=> pending_0 == ($past(ext_flag_0) & $past(reg_q[3])))
        else $error("pending not flag and enable");

    COV_FLAG_READ: cover property (reg_q[1][irq_bank_pkg::DMA_CH5_DONE_FLAG] && access_done && !pwrite
        && paddr == irq_bank_pkg::OFS_FLAG_3);
    COV_SET_VS_CLEAR: cover property (src_set_4[irq_bank_pkg::CAN_A_TX_REQUEST_FLAG] && reg_wr[2]);
    COV_PENDING: cover property (pending_0[irq_bank_pkg::TIMER_ONE_ENABLE]);
    COV_BUS_ERR: cover property (pslverr && irq);
    COV_SET_WINS_B: cover property (src_set_3[irq_bank_pkg::CAN_B_EVENT_FLAG] && reg_wr[1]);
endmodule
`default_nettype wire

// *** hdl/irq_bank_pkg.sv ***
// constants shared by the interrupt flag and enable bank
package irq_bank_pkg;
    // bus and register geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int NUM_REGS = 5;
    localparam int EVT_W = 2;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_FLAG_2 = 8'h00;
    localparam logic [7:0] OFS_FLAG_3 = 8'h04;
    localparam logic [7:0] OFS_FLAG_4 = 8'h08;
    localparam logic [7:0] OFS_ENABLE_0 = 8'h0c;
    localparam logic [7:0] OFS_ENABLE_1 = 8'h10;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h14;
    localparam logic [7:0] OFS_EVT_CLEAR = 8'h18;
    localparam logic [7:0] OFS_EVT_ENABLE = 8'h1c;

    // implemented bit masks; bits outside a mask read as zero
    localparam logic [15:0] MASK_FLAG_2 = 16'h000f;
    localparam logic [15:0] MASK_FLAG_3 = 16'h21ff;
    localparam logic [15:0] MASK_FLAG_4 = 16'h00f6;
    localparam logic [15:0] MASK_ENABLE_0 = 16'h7fff;
    localparam logic [15:0] MASK_ENABLE_1 = 16'hfffb;

    // reset values
    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [1:0] RST_EVT = 2'h0;

    // bank event bits
    localparam int EVT_REQUEST = 0;
    localparam int EVT_BUS_ERR = 1;

    // third flag register positions
    localparam int CAN_A_EVENT_FLAG = 3;
    localparam int CAN_A_RX_READY_FLAG = 2;
    localparam int SPI_B_EVENT_FLAG = 1;
    localparam int SPI_B_ERROR_FLAG = 0;
    // fourth flag register positions
    localparam int DMA_CH5_DONE_FLAG = 13;
    localparam int CAN_B_EVENT_FLAG = 8;
    localparam int CAN_B_RX_READY_FLAG = 7;
    localparam int EXT_IRQ4_FLAG = 6;
    localparam int EXT_IRQ3_FLAG = 5;
    localparam int TIMER_NINE_FLAG = 4;
    localparam int TIMER_EIGHT_FLAG = 3;
    localparam int I2C_B_MASTER_FLAG = 2;
    localparam int I2C_B_SLAVE_FLAG = 1;
    localparam int TIMER_SEVEN_FLAG = 0;
    // fifth flag register positions
    localparam int CAN_B_TX_REQUEST_FLAG = 7;
    localparam int CAN_A_TX_REQUEST_FLAG = 6;
    localparam int DMA_CH7_DONE_FLAG = 5;
    localparam int DMA_CH6_DONE_FLAG = 4;
    localparam int UART_B_ERROR_FLAG = 2;
    localparam int UART_A_ERROR_FLAG = 1;
    // first enable register positions
    localparam int DMA_CH1_DONE_ENABLE = 14;
    localparam int ADC_A_DONE_ENABLE = 13;
    localparam int UART_A_TX_ENABLE = 12;
    localparam int UART_A_RX_ENABLE = 11;
    localparam int SPI_A_EVENT_ENABLE = 10;
    localparam int SPI_A_ERROR_ENABLE = 9;
    localparam int TIMER_THREE_ENABLE = 8;
    localparam int TIMER_TWO_ENABLE = 7;
    localparam int COMPARE_TWO_ENABLE = 6;
    localparam int CAPTURE_TWO_ENABLE = 5;
    localparam int DMA_CH0_DONE_ENABLE = 4;
    localparam int TIMER_ONE_ENABLE = 3;
    localparam int COMPARE_ONE_ENABLE = 2;
    localparam int CAPTURE_ONE_ENABLE = 1;
    localparam int EXT_IRQ0_ENABLE = 0;
    // second enable register positions
    localparam int UART_B_TX_ENABLE = 15;
    localparam int UART_B_RX_ENABLE = 14;
    localparam int EXT_IRQ2_ENABLE = 13;
    localparam int TIMER_FIVE_ENABLE = 12;
    localparam int TIMER_FOUR_ENABLE = 11;
    localparam int COMPARE_FOUR_ENABLE = 10;
    localparam int COMPARE_THREE_ENABLE = 9;
    localparam int DMA_CH2_DONE_ENABLE = 8;
    localparam int CAPTURE_EIGHT_ENABLE = 7;
    localparam int CAPTURE_SEVEN_ENABLE = 6;
    localparam int ADC_B_DONE_ENABLE = 5;
    localparam int EXT_IRQ1_ENABLE = 4;
    localparam int CHANGE_NOTIFY_ENABLE = 3;
    localparam int I2C_A_MASTER_ENABLE = 1;
    localparam int I2C_A_SLAVE_ENABLE = 0;

    // bank register index to byte offset
    function automatic logic [7:0] reg_offset(input int idx);
        case (idx)
            0: reg_offset = OFS_FLAG_2;
            1: reg_offset = OFS_FLAG_3;
            2: reg_offset = OFS_FLAG_4;
            3: reg_offset = OFS_ENABLE_0;
            default: reg_offset = OFS_ENABLE_1;
        endcase
    endfunction

    // bank register index to implemented mask
    function automatic logic [15:0] reg_mask(input int idx);
        case (idx)
            0: reg_mask = MASK_FLAG_2;
            1: reg_mask = MASK_FLAG_3;
            2: reg_mask = MASK_FLAG_4;
            3: reg_mask = MASK_ENABLE_0;
            default: reg_mask = MASK_ENABLE_1;
        endcase
    endfunction
endpackage

// *** hdl/sticky_reg16.sv ***
// one 16-bit flag or enable register with hardware set and software write
`timescale 1ns/100ps
`default_nettype none
module sticky_reg16 #(
    parameter logic [15:0] IMPL_MASK = 16'hffff
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // hardware set pulses, one per bit
    input wire logic [15:0] hw_set,
    // software write
    input wire logic sw_wr,
    input wire logic [15:0] sw_data,
    // register contents
    output logic [15:0] value
);
    // one flop per implemented bit, unimplemented bits tied to zero
    genvar b;
    generate
        for (b = 0; b < 16; b++) begin : g_bit
            if (IMPL_MASK[b]) begin : g_impl
                logic bit_r;
                // hardware set beats a simultaneous software clear
                always_ff @(posedge mclk) begin
                    if (rst) begin
                        bit_r <= 1'b0;
                    end else begin
                        bit_r <= hw_set[b] | (sw_wr ? sw_data[b] : bit_r);
                    end
                end
                assign value[b] = bit_r;
            end else begin : g_unimpl
                assign value[b] = 1'b0;
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** verif/irq_source_model.sv ***
// peripheral source model: turns a bench request into one-cycle set pulses
`timescale 1ns/100ps
`default_nettype none
module irq_source_model (
    // clock
    input wire logic mclk,
    // request from the bench
    input wire logic fire,
    input wire logic [1:0] sel,
    input wire logic [15:0] bits,
    // set pulses toward the bank
    output logic [15:0] src_set_2,
    output logic [15:0] src_set_3,
    output logic [15:0] src_set_4
);
    // one cycle per request; lines rest at zero so a held level cannot mask a lost set
    always_ff @(posedge mclk) begin
        src_set_2 <= (fire && sel == 2'h0) ? bits : 16'h0000;
        src_set_3 <= (fire && sel == 2'h1) ? bits : 16'h0000;
        src_set_4 <= (fire && sel == 2'h2) ? bits : 16'h0000;
    end
endmodule
`default_nettype wire

// *** verif/irq_flag_enable_bank_test.sv ***
// self-checking bench for the interrupt flag and enable bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch %0t got %h exp %h", $time, got, exp); end end
module irq_flag_enable_bank_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rerr, irq;
    logic fire = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [15:0] bits = 16'h0000;
    logic [15:0] src_set_2, src_set_3, src_set_4, flag_2, flag_3, flag_4, enable_0, enable_1;
    logic [15:0] pending_0, pending_1, pending_2, pending_3, pending_4;
    logic [15:0] ext_enable_2 = 16'h0, ext_enable_3 = 16'h0, ext_enable_4 = 16'h0;
    logic [15:0] ext_flag_0 = 16'h0, ext_flag_1 = 16'h0;
    int errors = 0;
    int n_tests = 0;
    logic [7:0] ofs [5] = '{irq_bank_pkg::OFS_FLAG_2, irq_bank_pkg::OFS_FLAG_3, irq_bank_pkg::OFS_FLAG_4,
        irq_bank_pkg::OFS_ENABLE_0, irq_bank_pkg::OFS_ENABLE_1};
    // implemented bits per register, worked out from the bit maps
    logic [15:0] msk [5] = '{16'h000f, 16'h21ff, 16'h00f6, 16'h7fff, 16'hfffb};

    irq_flag_enable_bank dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .src_set_2, .src_set_3, .src_set_4, .ext_enable_2, .ext_enable_3, .ext_enable_4,
        .ext_flag_0, .ext_flag_1, .flag_2, .flag_3, .flag_4, .enable_0, .enable_1, .pending_2,
        .pending_3, .pending_4, .pending_0, .pending_1, .irq);
    irq_source_model src (.mclk, .fire, .sel, .bits, .src_set_2, .src_set_3, .src_set_4);

    // free-running system clock
    always #10 mclk = ~mclk;

    // one apb transfer; request held until pready is seen, data taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            errors++;
            $display("mismatch %0t no apb answer", $time);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // source request; the bank sees the set pulse at the edge this returns on
    task automatic pulse(input logic [1:0] s, input logic [15:0] b);
        @(posedge mclk);
        fire <= 1'b1;
        sel <= s;
        bits <= b;
        @(posedge mclk);
        fire <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic test_reset();
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            `CHK(rdata, 32'h0)
        end
        `CHK({flag_2, flag_3, flag_4, enable_0, enable_1}, 80'h0)
    endtask

    // all ones then zeros; unimplemented bits must stay zero
    task automatic test_rw();
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ofs[i], 32'hffffffff);
            apb(1'b0, ofs[i], 32'h0);
            `CHK(rdata, {16'h0, msk[i]})
        end
        `CHK({flag_2, flag_3, flag_4}, {msk[0], msk[1], msk[2]})
        `CHK({enable_0, enable_1}, {msk[3], msk[4]})
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ofs[i], 32'h0);
            apb(1'b0, ofs[i], 32'h0);
            `CHK(rdata, 32'h0)
        end
    endtask

    // every bit position set by its source, held, then cleared by software
    task automatic test_hw_set();
        logic [15:0] b;
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 16; k++) begin
                b = 16'h0001 << k;
                pulse(r[1:0], b);
                apb(1'b0, ofs[r], 32'h0);
                `CHK(rdata, {16'h0, b & msk[r]})
                apb(1'b1, ofs[r], 32'h0);
                apb(1'b0, ofs[r], 32'h0);
                `CHK(rdata, 32'h0)
            end
        end
    endtask

    // a set landing on the same edge as a software clear survives it
    task automatic test_set_wins();
        pulse(2'h1, 16'h0001);
        fork
            apb(1'b1, ofs[1], 32'h0);
            pulse(2'h1, 16'h0100);
        join
        apb(1'b0, ofs[1], 32'h0);
        `CHK(rdata, 32'h00000100)
        apb(1'b1, ofs[1], 32'h0);
    endtask

    task automatic test_pending();
        for (int r = 0; r < 3; r++) pulse(r[1:0], 16'hffff);
        apb(1'b1, ofs[3], 32'h00001234);
        apb(1'b1, ofs[4], 32'h000000f7);
        @(posedge mclk);
        ext_enable_2 <= 16'h000a;
        ext_enable_3 <= 16'h2101;
        ext_enable_4 <= 16'h0084;
        ext_flag_0 <= 16'hffff;
        ext_flag_1 <= 16'h555d;
        repeat (4) @(posedge mclk);
        `CHK({pending_2, pending_3, pending_4}, 48'h000a_2101_0084)
        `CHK({pending_0, pending_1}, 32'h1234_0051)
        ext_enable_3 <= 16'h0000;
        ext_flag_1 <= 16'h0000;
        repeat (4) @(posedge mclk);
        `CHK({pending_3, pending_1}, 32'h0)
        for (int i = 0; i < 5; i++) apb(1'b1, ofs[i], 32'h0);
        repeat (4) @(posedge mclk);
        `CHK({pending_2, pending_4, pending_0}, 48'h0)
    endtask

    // event status, enable, clear and refused accesses
    task automatic test_irq();
        apb(1'b1, irq_bank_pkg::OFS_EVT_CLEAR, 32'h3);
        apb(1'b1, irq_bank_pkg::OFS_EVT_ENABLE, 32'h1);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b0)
        pulse(2'h2, 16'h0002);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b1)
        apb(1'b1, irq_bank_pkg::OFS_EVT_STATUS, 32'h0);
        apb(1'b0, irq_bank_pkg::OFS_EVT_STATUS, 32'h0);
        `CHK(rdata, 32'h1)
        apb(1'b1, irq_bank_pkg::OFS_EVT_ENABLE, 32'h0);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b0)
        apb(1'b0, 8'h20, 32'h0);
        `CHK({rerr, rdata}, 33'h100000000)
        apb(1'b1, 8'h24, 32'hffffffff);
        `CHK(rerr, 1'b1)
        apb(1'b0, irq_bank_pkg::OFS_EVT_STATUS, 32'h0);
        `CHK({rerr, rdata}, 33'h3)
        apb(1'b1, irq_bank_pkg::OFS_EVT_ENABLE, 32'h2);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b1)
        apb(1'b1, irq_bank_pkg::OFS_EVT_CLEAR, 32'h3);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b0)
        apb(1'b0, irq_bank_pkg::OFS_EVT_CLEAR, 32'h0);
        `CHK(rdata, 32'h0)
    endtask

    task automatic print_verdict();
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // main sequence after eight reset cycles
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        test_reset();
        test_rw();
        test_hw_set();
        test_set_wins();
        test_pending();
        test_irq();
        print_verdict();
    end

    // watchdog; the whole run needs well under a tenth of this
    initial begin
        #400000;
        errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
